// ---- inc/rng_regs_pkg.sv ----
// Register map, field layout and timing constants of the random number register block.
// Assumes a 32-bit plain register port and one 250 MHz clock.
package rng_regs_pkg;

    localparam int unsigned ADDR_W            = 8;
    localparam int unsigned DATA_W            = 32;

    // Register byte offsets
    localparam logic [7:0]  OFF_GEN_CONTROL   = 8'h00;
    localparam logic [7:0]  OFF_IRQ_EN_SET    = 8'h10;
    localparam logic [7:0]  OFF_IRQ_EN_CLEAR  = 8'h14;
    localparam logic [7:0]  OFF_IRQ_MASK_VIEW = 8'h18;
    localparam logic [7:0]  OFF_IRQ_STATUS    = 8'h1c;
    localparam logic [7:0]  OFF_RANDOM_OUTPUT = 8'h50;

    // Field positions
    localparam int unsigned ENABLE_BIT        = 0;
    localparam int unsigned READY_BIT         = 0;
    localparam int unsigned KEY_LSB           = 8;
    localparam int unsigned KEY_W             = 24;
    localparam logic [23:0] VALID_PASSWORD_VALUE = 24'h524e47;

    // Reset values
    localparam logic [31:0] RANDOM_WORD_RESET = 32'h0000_0000;
    localparam logic        MASK_RESET        = 1'b0;
    localparam logic        READY_RESET       = 1'b0;
    localparam logic        ENABLE_RESET      = 1'b0;

    // Word production period in interface clock cycles
    localparam int unsigned WORD_PERIOD_CYC   = 84;
    localparam int unsigned PERIOD_CNT_W      = 7;
    localparam logic [31:0] LFSR_SEED         = 32'h1d87_2b41;

    // Register port request
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;

endpackage

// ---- rtl/entropy_word_source.sv ----
// Stand-in entropy producer: a free-running 32-bit shift register mixed with an
// external noise bit; emits a completed word every word period while enabled.
// Assumes noise_bit_in is already synchronised to sys_clk_in.
`timescale 1ns/1ps
`default_nettype none
module entropy_word_source
    import rng_regs_pkg::*;
#(
    parameter int unsigned PERIOD = WORD_PERIOD_CYC
) (
    input  wire logic        sys_clk_in,   // Interface clock
    input  wire logic        rst_n_in,     // Async reset, active low
    input  wire logic        run_in,       // Generator enabled
    input  wire logic        noise_bit_in, // Synchronised noise bit
    output logic [31:0]      word_out,     // Completed word
    output logic             word_done_out // One-cycle completion pulse
);
    import rng_regs_pkg::*;

    logic [31:0]             lfsr_r;
    logic [PERIOD_CNT_W-1:0] cnt_r;

    ////////////////////////////////////////////////////////////////
    // Shift register keeps stirring, noise folded into feedback
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            lfsr_r <= LFSR_SEED;
        end else begin
            lfsr_r <= {lfsr_r[30:0], lfsr_r[31] ^ lfsr_r[21] ^ lfsr_r[1] ^ lfsr_r[0] ^ noise_bit_in};
        end
    end

    // Period counter, restarts on each disable
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_r <= '0;
        end else if (!run_in || cnt_r == PERIOD_CNT_W'(PERIOD - 1)) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    // Word completes on last cycle of each period
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            word_out      <= RANDOM_WORD_RESET;
            word_done_out <= 1'b0;
        end else begin
            word_done_out <= run_in && (cnt_r == PERIOD_CNT_W'(PERIOD - 1));
            if (run_in && cnt_r == PERIOD_CNT_W'(PERIOD - 1)) begin
                word_out <= lfsr_r;
            end
        end
    end
endmodule
`default_nettype wire

// ---- rtl/random_number_register_interface.sv ----
// Software register interface of the random number generator: key-protected
// enable, data-ready mask, read-clear status and the output word.
// Assumes a single-cycle strobe master on the same clock; noise pin is asynchronous.
`timescale 1ns/1ps
`default_nettype none
module random_number_register_interface
    import rng_regs_pkg::*;
(
    input  wire logic                 sys_clk_in,   // 250 MHz clock
    input  wire logic                 rst_n_in,     // Async reset, active low
    input  wire rng_regs_pkg::reg_req_t req_in,     // Register request
    input  wire logic                 noise_pin_in, // Raw noise pin
    output logic [31:0]               rdata_out,    // Read data, cycle after strobe
    output logic                      irq_out,      // Data-ready interrupt
    output logic                      running_out   // Generator enabled
);
    import rng_regs_pkg::*;

    logic        enable_r;
    logic        mask_r;
    logic        ready_r;
    logic [31:0] random_word_r;
    logic [31:0] rdata_nxt;
    logic        noise_s1_r;
    logic        noise_s2_r;
    logic [31:0] src_word;
    logic        src_done;
    logic        key_ok;
    logic        status_rd;

    ////////////////////////////////////////////////////////////////
    // Noise pin synchroniser
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            noise_s1_r <= 1'b0;
            noise_s2_r <= 1'b0;
        end else begin
            noise_s1_r <= noise_pin_in;
            noise_s2_r <= noise_s1_r;
        end
    end

    // Word producer
    entropy_word_source #(
        .PERIOD        (WORD_PERIOD_CYC)
    ) u_source (
        .sys_clk_in    (sys_clk_in),
        .rst_n_in      (rst_n_in),
        .run_in        (enable_r),
        .noise_bit_in  (noise_s2_r),
        .word_out      (src_word),
        .word_done_out (src_done)
    );

    ////////////////////////////////////////////////////////////////
    // Decode helpers
    assign key_ok    = (req_in.wdata[KEY_LSB +: KEY_W] == VALID_PASSWORD_VALUE);
    assign status_rd = req_in.rd && (req_in.addr == OFF_IRQ_STATUS);

    // Keyed enable
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            enable_r <= ENABLE_RESET;
        end else if (req_in.wr && req_in.addr == OFF_GEN_CONTROL && key_ok) begin
            enable_r <= req_in.wdata[ENABLE_BIT];
        end
    end

    // Ready mask, set and clear registers
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mask_r <= MASK_RESET;
        end else if (req_in.wr && req_in.addr == OFF_IRQ_EN_SET && req_in.wdata[READY_BIT]) begin
            mask_r <= 1'b1;
        end else if (req_in.wr && req_in.addr == OFF_IRQ_EN_CLEAR && req_in.wdata[READY_BIT]) begin
            mask_r <= 1'b0;
        end
    end

    // Output word capture
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            random_word_r <= RANDOM_WORD_RESET;
        end else if (src_done) begin
            random_word_r <= src_word;
        end
    end

    // Ready flag: new word wins over a clearing read
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ready_r <= READY_RESET;
        end else if (!enable_r) begin
            ready_r <= 1'b0;
        end else if (src_done) begin
            ready_r <= 1'b1;
        end else if (status_rd) begin
            ready_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Read mux, unmapped and write-only offsets read zero
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (req_in.rd) begin
            case (req_in.addr)
                OFF_IRQ_MASK_VIEW: rdata_nxt[READY_BIT] = mask_r;
                OFF_IRQ_STATUS:    rdata_nxt[READY_BIT] = ready_r && enable_r;
                OFF_RANDOM_OUTPUT: rdata_nxt = random_word_r;
                default:           rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    // Read data registered, valid only the cycle after the strobe
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_out <= 32'h0000_0000;
        end else begin
            rdata_out <= rdata_nxt;
        end
    end

    // Interrupt and status outputs
    // Gated by enable so a disable drops the line at once, not one cycle late
    assign irq_out     = ready_r && mask_r && enable_r;
    assign running_out = enable_r;
endmodule
`default_nettype wire

// ---- verif/rng_regs_monitor.sv ----
// Port checker for the random number register block.
// Assumes it is bound onto the block and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module rng_regs_monitor
    import rng_regs_pkg::*;
(
    input wire logic                  sys_clk_in,  // Clock
    input wire logic                  rst_n_in,    // Reset, active low
    input wire rng_regs_pkg::reg_req_t req_in,     // Register request
    input wire logic [31:0]           rdata_out,   // Read data
    input wire logic                  irq_out,     // Interrupt
    input wire logic                  running_out  // Generator enabled
);
    import rng_regs_pkg::*;
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    ////////////////////////////////////////////////////////////////////////
    // Request shapes
    logic key_ok;
    assign key_ok = req_in.wdata[31:8] == VALID_PASSWORD_VALUE;
    sequence s_ctl(logic b);
        req_in.wr && req_in.addr == OFF_GEN_CONTROL && key_ok && req_in.wdata[0] == b;
    endsequence
    sequence s_wr1(logic [7:0] a);
        req_in.wr && req_in.addr == a && req_in.wdata[0];
    endsequence
    sequence s_rd(logic [7:0] a);
        req_in.rd && req_in.addr == a;
    endsequence
    ////////////////////////////////////////////////////////////////////////
    // Port relations
    AST_ENABLE: assert property (s_ctl(1'b1) |=> running_out)
        else $error("keyed enable not taken");
    AST_DISABLE: assert property (s_ctl(1'b0) |=> !running_out)
        else $error("keyed disable not taken");
    AST_BAD_KEY: assert property (req_in.wr && req_in.addr == OFF_GEN_CONTROL && !key_ok |=> $stable(running_out))
        else $error("wrong key changed state");
    AST_MASK_SET: assert property (s_wr1(OFF_IRQ_EN_SET) ##1 s_rd(OFF_IRQ_MASK_VIEW) |=> rdata_out == 32'h0000_0001)
        else $error("mask not set");
    AST_MASK_CLR: assert property (s_wr1(OFF_IRQ_EN_CLEAR) ##1 s_rd(OFF_IRQ_MASK_VIEW) |=> rdata_out == 32'h0000_0000)
        else $error("mask not cleared");
    AST_RESERVED: assert property (req_in.rd && !(req_in.addr inside {8'h18, 8'h1c, 8'h50}) |=> rdata_out == 32'h0)
        else $error("reserved read not zero");
    AST_OFF_FLAG: assert property (req_in.rd && req_in.addr == OFF_IRQ_STATUS && !running_out |=> rdata_out == 32'h0)
        else $error("ready shown while disabled");
    AST_IRQ_GATE: assert property (irq_out |-> running_out)
        else $error("interrupt while disabled");
    AST_IRQ_FALL: assert property ($fell(irq_out) |-> $past(req_in.rd || req_in.wr))
        else $error("interrupt dropped on its own");
endmodule
`default_nettype wire

// ---- verif/tb_top.sv ----
// Self-checking bench for the random number register block.
// Assumes the package constants and a single 250 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import rng_regs_pkg::*;
    logic sys_clk_in, rst_n_in, noise, irq_out, running_out;
    logic [31:0] rdata_out, rv;
    reg_req_t req;
    int n_mismatch, checks, cyc, t1, t2;
    logic [7:0] rows [8] = '{8'h00, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h50, 8'h04, 8'h54};
    random_number_register_interface DUT (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .req_in(req),
        .noise_pin_in(noise), .rdata_out(rdata_out), .irq_out(irq_out), .running_out(running_out));
    ////////////////////////////////////////////////////////////////////////
    // Clock, cycle count and noise
    initial begin
        sys_clk_in = 1'b0;
        forever #2 sys_clk_in = ~sys_clk_in;
    end
    always @(posedge sys_clk_in) begin
        cyc <= cyc + 1;
        noise <= cyc[0] ^ cyc[3];
    end
    ////////////////////////////////////////////////////////////////////////
    // Bus and check tasks
    task automatic go(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_in);
        req <= '{addr: a, wdata: d, wr: w, rd: r};
    endtask
    task automatic rd(input logic [7:0] a);
        go(1'b0, 1'b1, a, 32'h0);
        go(1'b0, 1'b0, 8'h00, 32'h0);
        #1 rv = rdata_out;
    endtask
    task automatic chk(input logic ok);
        checks++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("FAIL %0t port value mismatch", $time);
        end
    endtask
    task automatic report_and_stop();
        if (n_mismatch == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic wait_irq(output int t);
        int n;
        for (n = 0; n < 300 && irq_out !== 1'b1; n++) @(posedge sys_clk_in) #1;
        t = cyc;
        if (n >= 300) begin
            n_mismatch++;
            report_and_stop();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        rst_n_in = 1'b0;
        req = '0;
        repeat (8) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        go(1'b1, 1'b0, 8'h00, {24'h524e46, 8'h01});
        go(1'b1, 1'b0, 8'h1c, 32'hffff_ffff);
        go(1'b1, 1'b0, 8'h50, 32'hffff_ffff);
        go(1'b1, 1'b0, 8'h18, 32'hffff_ffff);
        go(1'b0, 1'b0, 8'h00, 32'h0);
        chk(running_out === 1'b0);
        foreach (rows[i]) begin
            rd(rows[i]);
            chk(rv === 32'h0);
        end
        go(1'b1, 1'b0, OFF_IRQ_EN_SET, 32'hffff_fffe);
        rd(OFF_IRQ_MASK_VIEW);
        chk(rv === 32'h0);
        go(1'b1, 1'b0, OFF_IRQ_EN_SET, 32'h1);
        rd(OFF_IRQ_MASK_VIEW);
        chk(rv === 32'h1);
        go(1'b1, 1'b0, OFF_GEN_CONTROL, {VALID_PASSWORD_VALUE, 8'h01});
        rd(OFF_IRQ_STATUS);
        chk(running_out === 1'b1 && rv === 32'h0);
        wait_irq(t1);
        rd(OFF_IRQ_STATUS);
        chk(rv === 32'h1 && irq_out === 1'b0);
        rd(OFF_IRQ_STATUS);
        chk(rv === 32'h0);
        rd(OFF_RANDOM_OUTPUT);
        chk(rv !== 32'h0);
        wait_irq(t2);
        chk(t2 - t1 == WORD_PERIOD_CYC);
        go(1'b1, 1'b0, OFF_IRQ_EN_CLEAR, 32'h1);
        rd(OFF_IRQ_MASK_VIEW);
        chk(rv === 32'h0 && irq_out === 1'b0);
        rd(OFF_IRQ_STATUS);
        repeat (90) @(posedge sys_clk_in);
        chk(irq_out === 1'b0);
        rd(OFF_IRQ_STATUS);
        chk(rv === 32'h1);
        go(1'b1, 1'b0, OFF_GEN_CONTROL, 32'h0);
        rd(OFF_IRQ_STATUS);
        chk(running_out === 1'b1);
        go(1'b1, 1'b0, OFF_GEN_CONTROL, {VALID_PASSWORD_VALUE, 8'h00});
        rd(OFF_IRQ_STATUS);
        chk(running_out === 1'b0 && rv === 32'h0);
        go(1'b1, 1'b0, OFF_IRQ_EN_SET, 32'h1);
        go(1'b0, 1'b0, 8'h00, 32'h0);
        rst_n_in <= 1'b0;
        repeat (3) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        rd(OFF_IRQ_MASK_VIEW);
        chk(rv === 32'h0);
        report_and_stop();
    end
endmodule
bind random_number_register_interface rng_regs_monitor mon (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .req_in(req_in), .rdata_out(rdata_out), .irq_out(irq_out), .running_out(running_out));
`default_nettype wire
